// ---- verilog/mlcd_pkg.sv ----
// constants, state type and sync bit layout of the monochrome row scan interface
package mlcd_pkg;

  // ************************************************************
  // panel geometry
  // ************************************************************
  localparam int COLS         = 640;                // dots per row
  localparam int ROWS         = 240;                // rows per frame, 1/240 duty
  localparam int NIB_W        = 4;                  // dots per shift clock
  localparam int DRV_DOTS     = 160;                // dots per column driver
  localparam int DRV_CNT      = COLS / DRV_DOTS;    // column drivers, left to right
  localparam int NIBS_PER_DRV = DRV_DOTS / NIB_W;   // shift clocks per driver
  localparam int ROW_W        = 8;                  // row index width
  localparam int POS_W        = 6;                  // nibble position width
  localparam int DRV_W        = 2;                  // driver select width

  localparam logic [ROW_W-1:0] ROW_FIRST = 8'h00;
  localparam logic [ROW_W-1:0] ROW_LAST  = ROW_W'(ROWS - 1);
  localparam logic [ROW_W-1:0] ROW_STEP  = 8'h01;
  localparam logic [POS_W-1:0] POS_FIRST = 6'h00;
  localparam logic [POS_W-1:0] POS_LAST  = POS_W'(NIBS_PER_DRV - 1);
  localparam logic [POS_W-1:0] POS_STEP  = 6'h01;
  localparam logic [DRV_W-1:0] DRV_FIRST = 2'h0;
  localparam logic [DRV_W-1:0] DRV_LAST  = DRV_W'(DRV_CNT - 1);
  localparam logic [DRV_W-1:0] DRV_STEP  = 2'h1;

  // ************************************************************
  // frame period window
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;                // system clock, 100 MHz
  localparam int FRAME_MIN_US  = 12_500;            // 12.5 ms
  localparam int FRAME_MAX_US  = 14_300;            // 14.3 ms
  localparam int FRAME_MIN_CYC = (FRAME_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_MAX_CYC = (FRAME_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int FCNT_W        = 21;                // frame cycle counter width
  localparam logic [FCNT_W-1:0] FCNT_ZERO = 21'h000000;
  localparam logic [FCNT_W-1:0] FCNT_STEP = 21'h000001;
  localparam logic [FCNT_W-1:0] FCNT_SAT  = 21'h1fffff;

  // ************************************************************
  // synchroniser bit layout
  // ************************************************************
  localparam int SY_LATCH  = 0;                     // line latch strobe
  localparam int SY_FRAME  = 1;                     // frame start
  localparam int SY_TOGGLE = 2;                     // drive waveform toggle
  localparam int SY_SHOW   = 3;                     // display blank control
  localparam int SY_READY  = 4;                     // row ready toggle from link
  localparam int SYS_SY_W  = 5;
  localparam int LK_RST    = 0;                     // reset into link domain
  localparam int LK_CE     = 1;                     // clock enable into link domain
  localparam int LK_SY_W   = 2;

  // scan state, gray coded
  typedef enum logic [1:0] {
    MLCD_ST_WAIT = 2'b00,                           // no frame start seen yet
    MLCD_ST_SCAN = 2'b01                            // rows are being scanned
  } mlcd_state_t;

endpackage

// ---- verilog/mlcd_sync_cell.sv ----
// two flip-flop level synchroniser for a group of bits
`timescale 1ns/1ps
`default_nettype none
module mlcd_sync_cell #(
  parameter int W = 1                       // bits to synchronise
) (
  input  wire logic         i_clk,          // destination clock
  input  wire logic [W-1:0] i_d,            // asynchronous levels
  output logic      [W-1:0] o_q             // synchronised levels
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (W < 1) begin : g_bad_w
    $error("sync width must be at least one");
  end

  logic [W-1:0] meta_ff;                    // first stage, read by sync_ff only
  logic [W-1:0] sync_ff;                    // second stage

  // both stages; free running so that reset and enable can cross
  always_ff @(posedge i_clk) begin
    meta_ff <= i_d;
    sync_ff <= meta_ff;
  end

  assign o_q = sync_ff;

endmodule
`default_nettype wire

// ---- verilog/mlcd_row_scan_if.sv ----
// row scan interface of a 640x240 monochrome panel: nibble capture, latch, scan
`timescale 1ns/1ps
`default_nettype none
module mlcd_row_scan_if
  import mlcd_pkg::*;
#(
  parameter int P_FRAME_MIN_CYC = FRAME_MIN_CYC,    // shortest legal frame in cycles
  parameter int P_FRAME_MAX_CYC = FRAME_MAX_CYC     // longest legal frame in cycles
) (
  input  wire logic             i_clk_sys,          // system clock
  input  wire logic             i_srst,             // synchronous reset
  input  wire logic             i_ce,               // clock enable
  input  wire logic             i_nibble_shift_clock, // link clock, falling edge
  input  wire logic [NIB_W-1:0] i_pixel_nibble,     // four dots, bit 0 leftmost
  input  wire logic             i_line_latch_strobe, // row latch, falling edge
  input  wire logic             i_frame_start,      // first row marker
  input  wire logic             i_drive_waveform_toggle, // polarity alternation
  input  wire logic             i_display_blank_control, // high shows
  output logic      [COLS-1:0]  o_column_drive,     // column drive data
  output logic      [ROW_W-1:0] o_scan_row,         // selected scan row
  output logic                  o_scan_valid,       // scanning since first frame start
  output logic                  o_drive_polarity,   // current drive polarity
  output logic                  o_display_on,       // display shown
  output logic                  o_row_underrun,     // last latch found no row
  output logic                  o_frame_len_err,    // last frame not 240 rows
  output logic                  o_frame_period_err  // last frame out of window
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (P_FRAME_MIN_CYC < 1 || P_FRAME_MIN_CYC > P_FRAME_MAX_CYC ||
      P_FRAME_MAX_CYC >= int'(FCNT_SAT)) begin : g_bad_frame
    $error("frame window parameters out of range");
  end

  localparam logic [FCNT_W-1:0] FMIN = FCNT_W'(P_FRAME_MIN_CYC);
  localparam logic [FCNT_W-1:0] FMAX = FCNT_W'(P_FRAME_MAX_CYC);

  // ************************************************************
  // link domain: nibble capture on the falling shift clock edge
  // ************************************************************
  logic                            link_clk;        // inverted shift clock
  logic [LK_SY_W-1:0]              lk_sync;         // reset and enable, link side
  logic                            lk_rst;          // link reset
  logic                            lk_ce;           // link clock enable
  logic [DRV_W-1:0]                drv_sel_ff;      // selected column driver
  logic [DRV_W-1:0]                nxt_drv_sel;
  logic [POS_W-1:0]                nib_pos_ff;      // nibble within driver
  logic [POS_W-1:0]                nxt_nib_pos;
  logic [DRV_CNT-1:0][DRV_DOTS-1:0] fill_ff;        // row being shifted in
  logic [DRV_CNT-1:0][DRV_DOTS-1:0] nxt_fill;
  logic [DRV_CNT-1:0][DRV_DOTS-1:0] hold_ff;        // last complete row
  logic [DRV_CNT-1:0][DRV_DOTS-1:0] nxt_hold;
  logic                            ready_tgl_ff;    // flips per complete row
  logic                            nxt_ready_tgl;

  assign link_clk = ~i_nibble_shift_clock;

  // reset and enable brought onto the link clock
  mlcd_sync_cell #(
    .W (LK_SY_W)
  ) u_lk_sync (
    .i_clk (link_clk),
    .i_d   ({i_ce, i_srst}),
    .o_q   (lk_sync)
  );

  assign lk_rst = lk_sync[LK_RST];
  assign lk_ce  = lk_sync[LK_CE];

  // next state of the capture logic
  always_comb begin
    nxt_drv_sel   = drv_sel_ff;
    nxt_nib_pos   = nib_pos_ff;
    nxt_fill      = fill_ff;
    nxt_hold      = hold_ff;
    nxt_ready_tgl = ready_tgl_ff;
    if (lk_ce) begin
      // only the selected driver takes the nibble
      nxt_fill[drv_sel_ff][nib_pos_ff * NIB_W +: NIB_W] = i_pixel_nibble;
      if (nib_pos_ff == POS_LAST) begin
        // driver full: hand selection to the right neighbour
        nxt_nib_pos = POS_FIRST;
        if (drv_sel_ff == DRV_LAST) begin
          // row complete: park it for the latch, restart at the left
          nxt_drv_sel   = DRV_FIRST;
          nxt_hold      = nxt_fill;
          nxt_ready_tgl = ~ready_tgl_ff;
        end else begin
          nxt_drv_sel = drv_sel_ff + DRV_STEP;
        end
      end else begin
        nxt_nib_pos = nib_pos_ff + POS_STEP;
      end
    end
  end

  // capture registers; row data need no reset, it is only read once full
  always_ff @(posedge link_clk) begin
    fill_ff <= nxt_fill;
    hold_ff <= nxt_hold;
    if (lk_rst) begin
      drv_sel_ff   <= DRV_FIRST;
      nib_pos_ff   <= POS_FIRST;
      ready_tgl_ff <= 1'b0;
    end else begin
      drv_sel_ff   <= nxt_drv_sel;
      nib_pos_ff   <= nxt_nib_pos;
      ready_tgl_ff <= nxt_ready_tgl;
    end
  end

  // ************************************************************
  // system domain: latch, scan and checks
  // ************************************************************
  logic [SYS_SY_W-1:0] sy;                  // synchronised pins and row toggle
  logic                latch_d_ff;          // previous latch level
  logic                nxt_latch_d;
  logic                tgl_d_ff;            // previous row toggle
  logic                nxt_tgl_d;
  logic                latch_fall;          // latch falling edge seen
  logic                ready_evt;           // a new row is parked
  mlcd_state_t         state_ff;            // scan state
  mlcd_state_t         nxt_state;
  logic [ROW_W-1:0]    row_ff;              // current scan row
  logic [ROW_W-1:0]    nxt_row;
  logic                pend_ff;             // parked row not yet latched
  logic                nxt_pend;
  logic [COLS-1:0]     col_latch_ff;        // latched row
  logic [COLS-1:0]     nxt_col_latch;
  logic [COLS-1:0]     col_out_ff;          // row as driven, blanked if off
  logic [COLS-1:0]     nxt_col_out;
  logic                pol_ff;              // drive polarity
  logic                nxt_pol;
  logic                show_ff;             // display shown
  logic                nxt_show;
  logic                under_ff;            // underrun status
  logic                nxt_under;
  logic                flen_ff;             // frame length status
  logic                nxt_flen;
  logic                fper_ff;             // frame period status
  logic                nxt_fper;
  logic [FCNT_W-1:0]   fcnt_ff;             // cycles since frame start
  logic [FCNT_W-1:0]   nxt_fcnt;

  // pins and the link row toggle onto the system clock
  mlcd_sync_cell #(
    .W (SYS_SY_W)
  ) u_sys_sync (
    .i_clk (i_clk_sys),
    .i_d   ({ready_tgl_ff, i_display_blank_control, i_drive_waveform_toggle,
             i_frame_start, i_line_latch_strobe}),
    .o_q   (sy)
  );

  assign latch_fall = latch_d_ff & ~sy[SY_LATCH];
  assign ready_evt  = tgl_d_ff ^ sy[SY_READY];

  // next state of latch, scan and status
  always_comb begin
    nxt_latch_d   = latch_d_ff;
    nxt_tgl_d     = tgl_d_ff;
    nxt_state     = state_ff;
    nxt_row       = row_ff;
    nxt_pend      = pend_ff;
    nxt_col_latch = col_latch_ff;
    nxt_col_out   = col_out_ff;
    nxt_pol       = pol_ff;
    nxt_show      = show_ff;
    nxt_under     = under_ff;
    nxt_flen      = flen_ff;
    nxt_fper      = fper_ff;
    nxt_fcnt      = fcnt_ff;
    if (i_ce) begin
      nxt_latch_d = sy[SY_LATCH];
      nxt_tgl_d   = sy[SY_READY];
      nxt_pol     = sy[SY_TOGGLE];
      nxt_show    = sy[SY_SHOW];
      // blank forces the columns off, the latched row is kept
      nxt_col_out = show_ff ? col_latch_ff : '0;
      // saturating frame timer
      if (fcnt_ff != FCNT_SAT) begin
        nxt_fcnt = fcnt_ff + FCNT_STEP;
      end
      if (latch_fall) begin
        if (sy[SY_FRAME]) begin
          // frame start rides this latch: back to the first row
          nxt_state = MLCD_ST_SCAN;
          nxt_row   = ROW_FIRST;
          nxt_fcnt  = FCNT_ZERO;
          if (state_ff == MLCD_ST_SCAN) begin
            // judge the frame just ended
            nxt_flen = (row_ff != ROW_LAST);
            nxt_fper = (fcnt_ff < FMIN) || (fcnt_ff > FMAX);
          end
        end else if (state_ff == MLCD_ST_SCAN) begin
          // step one row down, wrap after the last
          nxt_row = (row_ff == ROW_LAST) ? ROW_FIRST : row_ff + ROW_STEP;
        end
        if (pend_ff || ready_evt) begin
          // whole row goes to the columns at once
          nxt_col_latch = hold_ff;
          nxt_pend      = 1'b0;
          nxt_under     = 1'b0;
        end else begin
          // no full row arrived since the last latch
          nxt_under = 1'b1;
        end
      end else if (ready_evt) begin
        // a parked row waits for the latch
        nxt_pend = 1'b1;
      end
    end
  end

  // system registers
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      latch_d_ff   <= 1'b0;
      tgl_d_ff     <= 1'b0;
      state_ff     <= MLCD_ST_WAIT;
      row_ff       <= ROW_FIRST;
      pend_ff      <= 1'b0;
      col_latch_ff <= '0;
      col_out_ff   <= '0;
      pol_ff       <= 1'b0;
      show_ff      <= 1'b0;
      under_ff     <= 1'b0;
      flen_ff      <= 1'b0;
      fper_ff      <= 1'b0;
      fcnt_ff      <= FCNT_ZERO;
    end else begin
      latch_d_ff   <= nxt_latch_d;
      tgl_d_ff     <= nxt_tgl_d;
      state_ff     <= nxt_state;
      row_ff       <= nxt_row;
      pend_ff      <= nxt_pend;
      col_latch_ff <= nxt_col_latch;
      col_out_ff   <= nxt_col_out;
      pol_ff       <= nxt_pol;
      show_ff      <= nxt_show;
      under_ff     <= nxt_under;
      flen_ff      <= nxt_flen;
      fper_ff      <= nxt_fper;
      fcnt_ff      <= nxt_fcnt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_column_drive     = col_out_ff;
  assign o_scan_row         = row_ff;
  assign o_scan_valid       = (state_ff == MLCD_ST_SCAN);
  assign o_drive_polarity   = pol_ff;
  assign o_display_on       = show_ff;
  assign o_row_underrun     = under_ff;
  assign o_frame_len_err    = flen_ff;
  assign o_frame_period_err = fper_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  a_driver_handover: assert property (
    @(posedge link_clk) disable iff (lk_rst)
    (lk_ce && nib_pos_ff == POS_LAST && drv_sel_ff != DRV_LAST)
      |=> (drv_sel_ff == $past(drv_sel_ff) + DRV_STEP && nib_pos_ff == POS_FIRST))
    else $error("driver selection did not move right");

  a_row_complete: assert property (
    @(posedge link_clk) disable iff (lk_rst)
    (lk_ce && nib_pos_ff == POS_LAST && drv_sel_ff == DRV_LAST)
      |=> (ready_tgl_ff != $past(ready_tgl_ff) && drv_sel_ff == DRV_FIRST))
    else $error("complete row not parked");

  a_nibble_place: assert property (
    @(posedge link_clk) disable iff (lk_rst)
    (lk_ce && nib_pos_ff == POS_FIRST && drv_sel_ff == DRV_FIRST)
      |=> (fill_ff[0][NIB_W-1:0] == $past(i_pixel_nibble)))
    else $error("first nibble not at the left edge");

  a_first_row: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && latch_fall && sy[SY_FRAME]) |=> (o_scan_row == ROW_FIRST && o_scan_valid))
    else $error("frame start did not select row one");

  a_row_step: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && latch_fall && !sy[SY_FRAME] && o_scan_valid && row_ff != ROW_LAST)
      |=> (row_ff == $past(row_ff) + ROW_STEP))
    else $error("latch did not step one row down");

  a_row_bound: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (o_scan_row <= ROW_LAST))
    else $error("scan row beyond last row");

  a_frame_length: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && latch_fall && sy[SY_FRAME] && o_scan_valid && row_ff != ROW_LAST)
      |=> o_frame_len_err)
    else $error("short frame not flagged");

  a_row_load: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && latch_fall && (pend_ff || ready_evt))
      |=> (col_latch_ff == $past(hold_ff) && !o_row_underrun))
    else $error("latched row differs from shifted row");

  a_blank_output: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && !show_ff) |=> (o_column_drive == '0))
    else $error("columns driven while blanked");

  a_enable_freeze: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (!i_ce) |=> (row_ff == $past(row_ff) && o_column_drive == $past(o_column_drive)))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ---- verification/mlcd_ctl_model.sv ----
// behavioural display controller: shift clock and nibble bus
`timescale 1ns/1ps
`default_nettype none
module mlcd_ctl_model
  import mlcd_pkg::*;
(
  output logic             o_sclk, // shift clock, stands low between tasks, pulsed by rows and idle edges
  output logic [NIB_W-1:0] o_nib   // nibble bus
);
  // ************************************************************
  // idle levels
  // ************************************************************
  initial begin
    o_sclk = 1'b0;
    o_nib  = 4'h5;
  end

  // ************************************************************
  // shift clock tasks
  // ************************************************************
  // free edges with no data; bus keeps changing so nothing is held
  task automatic idle(input int n);
    repeat (n) begin
      o_sclk = 1'b1;
      o_nib  = ~o_nib;
      #15 o_sclk = 1'b0;
      #15;
    end
  endtask

  // one row of 160 nibbles, leftmost dots first, taken on falling edge
  task automatic send_row(input logic [COLS-1:0] d);
    for (int k = 0; k < COLS / NIB_W; k++) begin
      o_sclk = 1'b1;
      o_nib  = d[k*NIB_W +: NIB_W];
      #15 o_sclk = 1'b0;
      #15;
    end
    o_nib = ~o_nib; // released bus shows the inverse
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_mlcd_row_scan_if.sv ----
// self-checking bench of the monochrome row scan interface
`timescale 1ns/1ps
`default_nettype none
module tb_mlcd_row_scan_if;
  import mlcd_pkg::*;
  // expected state after one latch
  typedef struct packed {
    logic [COLS-1:0]  cols;
    logic [ROW_W-1:0] row;
    logic valid, under, chkf, flen, fper, pol;
  } mlcd_exp_t;

  logic             clk = 1'b0; // system clock
  logic             srst, ce, stb, fs, tog, show; // control pins
  logic             sclk;       // shift clock from the model
  logic [NIB_W-1:0] nib;        // nibble bus from the model
  logic [COLS-1:0]  cols;       // column drive
  logic [ROW_W-1:0] row;        // scan row
  logic             valid, pol, on, under, flen, fper; // status
  logic [COLS-1:0]  rd, row_b;  // row data
  logic [31:0]      seed = 32'h9fbc9987; // xorshift state
  int               num_errors = 0;
  int               total_checks = 0;
  mlcd_exp_t        e, m;       // expectation under build, popped one
  mlcd_exp_t        q[$];       // pending expectations
  event             latched;    // a latch was issued

  // ************************************************************
  // clock, design and controller
  // ************************************************************
  initial forever #5 clk = ~clk;

  mlcd_row_scan_if #(.P_FRAME_MIN_CYC(4000), .P_FRAME_MAX_CYC(8000)) mlcd_row_scan_if_inst (
    .i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_nibble_shift_clock(sclk),
    .i_pixel_nibble(nib), .i_line_latch_strobe(stb), .i_frame_start(fs),
    .i_drive_waveform_toggle(tog), .i_display_blank_control(show),
    .o_column_drive(cols), .o_scan_row(row), .o_scan_valid(valid),
    .o_drive_polarity(pol), .o_display_on(on), .o_row_underrun(under),
    .o_frame_len_err(flen), .o_frame_period_err(fper));

  mlcd_ctl_model mlcd_ctl_model_inst (.o_sclk(sclk), .o_nib(nib));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // random row from the xorshift stream
  task automatic rand_row();
    for (int i = 0; i < COLS / 32; i++) begin
      seed = xs(seed);
      rd[i*32 +: 32] = seed;
    end
  endtask

  task automatic check(input logic [COLS-1:0] seen, input logic [COLS-1:0] exp, input string s);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one latch pulse; f marks row one, p says a row was parked
  task automatic latch(input logic f, input logic p, input logic el, input logic ep);
    @(posedge clk) #1 stb = 1'b1;
    fs = f;
    if (f) tog = ~tog;
    repeat (10) @(posedge clk);
    #1 stb = 1'b0;
    e.chkf = f & e.valid; // flags refresh only while scanning
    if (f) begin
      e.valid = 1'b1;
      e.row   = ROW_FIRST;
    end else if (e.valid) begin
      e.row = (e.row == ROW_LAST) ? ROW_FIRST : e.row + ROW_STEP;
    end
    e.under = ~p;
    e.flen  = el;
    e.fper  = ep;
    e.pol   = tog;
    if (p) e.cols = rd;
    q.push_back(e);
    -> latched;
    repeat (11) @(posedge clk);
    #1 fs = 1'b0;
  endtask

  // ************************************************************
  // output watcher
  // ************************************************************
  initial forever begin
    @(latched);
    repeat (8) @(posedge clk);
    #1 m = q.pop_front();
    check(cols, show ? m.cols : COLS'(0), "column drive");
    check(COLS'(row), COLS'(m.row), "scan row");
    check(COLS'(valid), COLS'(m.valid), "scan valid");
    check(COLS'(under), COLS'(m.under), "row underrun");
    check(COLS'(pol), COLS'(m.pol), "drive polarity");
    if (m.chkf) begin
      check(COLS'(flen), COLS'(m.flen), "frame length flag");
      check(COLS'(fper), COLS'(m.fper), "frame period flag");
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {srst, ce, stb, fs, tog, show} = 6'b110000;
    e = '0;
    rd = '0;
    fork
      #1 mlcd_ctl_model_inst.idle(3); // link side needs three edges in reset
      repeat (9) @(posedge clk);
    join
    @(posedge clk) #1 srst = 1'b0;
    mlcd_ctl_model_inst.idle(2);
    repeat (2) @(posedge clk);
    #1 check(COLS'({row, valid, under}), COLS'(0), "idle after reset");
    latch(1'b0, 1'b0, 1'b0, 1'b0); // no row parked, not scanning
    @(posedge clk) #1 show = 1'b1;
    repeat (6) @(posedge clk);
    #1 check(COLS'(on), COLS'(1), "display shown");
    rand_row();
    mlcd_ctl_model_inst.send_row(rd);
    latch(1'b1, 1'b1, 1'b0, 1'b0); // first frame start
    rand_row();
    row_b = rd;
    mlcd_ctl_model_inst.send_row(rd);
    latch(1'b0, 1'b1, 1'b0, 1'b0);
    rand_row();
    mlcd_ctl_model_inst.send_row(rd);
    check(cols, row_b, "shown row held while shifting");
    latch(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk) #1 show = 1'b0;
    repeat (6) @(posedge clk);
    #1 check(COLS'({cols, on}), COLS'(0), "blanked");
    @(posedge clk) #1 show = 1'b1;
    repeat (6) @(posedge clk);
    #1 check(cols, rd, "unblanked keeps row");
    // enable low: a blank request must not reach the outputs
    ce   = 1'b0;
    show = 1'b0;
    repeat (6) @(posedge clk);
    #1 check(cols, rd, "enable low holds columns");
    check(COLS'(on), COLS'(1), "enable low holds shown level");
    show = 1'b1;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    latch(1'b1, 1'b0, 1'b1, 1'b1); // short and fast frame
    for (int i = 1; i < ROWS; i++) latch(1'b0, 1'b0, 1'b0, 1'b0);
    latch(1'b1, 1'b0, 1'b0, 1'b0); // full frame inside the window
    for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: watcher stalled", $time);
    end
    complete_run();
  end
endmodule
`default_nettype wire
